// ### pkg/chain_readout_pkg.sv
/*
 Shared constants for the daisy-chain serial result readout.
 Assumes a 50 MHz system clock and 12-bit two's complement results.
*/
`default_nettype none
package chain_readout_pkg;
	localparam int WORD_W = 12;
	localparam int RAW_W = 14;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	localparam logic [3:0] SLOT_BITS = 4'hd;
	localparam logic [3:0] WORD_BITS = 4'hc;
	localparam int CLK_PERIOD_NS = 20;
	localparam int INT_CLK_PERIOD_NS = 820;
	localparam int INT_CLK_CYCLES = INT_CLK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [5:0] INT_TICK_LAST = 6'(INT_CLK_CYCLES - 1);
	localparam logic signed [RAW_W-1:0] RAW_MAX = 14'sh07ff;
	localparam logic signed [RAW_W-1:0] RAW_MIN = -14'sh0800;
	localparam logic [WORD_W-1:0] CODE_POS_FS = 12'h7ff;
	localparam logic [WORD_W-1:0] CODE_NEG_FS = 12'h800;
	localparam int SYN_SCLK = 0;
	localparam int SYN_CS_N = 1;
	localparam int SYN_RC = 2;
	localparam int SYN_CHAIN = 3;
	localparam int SYN_EXT = 4;
	localparam int SYN_W = 5;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_READ = 2'b10
	} read_state_t;
endpackage : chain_readout_pkg
`default_nettype wire

// ### logic/chain_readout.sv
/*
 Serial result readout with chain input, plus its result FIFO.
 Assumes pins are asynchronous to clk and the shift clock is far slower.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Shift one bit per external clock falling edge
// - No separator bit between consecutive words
// - Output ends cycle at start chain level
// - End level rule holds in every mode
// - Internal mode: output follows chain after 13 ticks
// - Out-of-range inputs saturate, never wrap
// - Output shifts only when selected and reading; goes to start level on deselect
// - MSB after first fall, LSB after twelfth
// - First chain bit appears at thirteenth fall

module sample_fifo #(
	parameter int W = 12,
	parameter int D = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam logic [AW:0] DEPTH_C = (AW+1)'(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic ready_q;
	logic push;
	logic pop;

	assign push = in_valid && ready_q;
	assign pop = out_valid && out_ready;
	assign out_valid = cnt_q != '0;
	assign out_data = mem[rd_q];
	assign in_ready = ready_q;

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (clk_en && push) begin
			mem[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b0;
		end else if (clk_en) begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_d;
			ready_q <= cnt_d != DEPTH_C;
		end
	end
endmodule : sample_fifo

module chain_readout (
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic shift_clock,
	input wire logic chip_select_n,
	input wire logic read_convert,
	input wire logic chain_in,
	input wire logic clock_source_select,
	input wire logic signed [chain_readout_pkg::RAW_W-1:0] raw_sample,
	input wire logic sample_valid,
	output logic sample_ready,
	output logic serial_result_out
);
	import chain_readout_pkg::*;

	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	logic sclk_prev_q;
	logic rise;
	logic fall;
	logic en;
	logic ext;
	logic tick;
	logic shift_ev;
	logic in_bit;
	logic tag_q;
	logic start_tag_q;
	logic [WORD_W-1:0] sreg_q;
	logic [3:0] cnt_q;
	logic [5:0] div_q;
	logic [WORD_W-1:0] sat_code;
	logic [WORD_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	read_state_t state_q;

	// Two-stage synchronisers for all pins
	always_ff @(posedge clk) begin
		if (rst) begin
			syn1_q <= '0;
			syn2_q <= '0;
			sclk_prev_q <= 1'b0;
		end else if (clk_en) begin
			syn1_q <= {clock_source_select, chain_in, read_convert,
				chip_select_n, shift_clock};
			syn2_q <= syn1_q;
			sclk_prev_q <= syn2_q[SYN_SCLK];
		end
	end

	assign rise = syn2_q[SYN_SCLK] && !sclk_prev_q;
	assign fall = !syn2_q[SYN_SCLK] && sclk_prev_q;
	assign en = !syn2_q[SYN_CS_N] && syn2_q[SYN_RC];
	assign ext = syn2_q[SYN_EXT];
	assign tick = div_q == INT_TICK_LAST;
	assign shift_ev = ext ? fall : tick;
	assign in_bit = ext ? tag_q : syn2_q[SYN_CHAIN];

	// Saturating conversion code
	always_comb begin
		if (raw_sample > RAW_MAX) begin
			sat_code = CODE_POS_FS;
		end else if (raw_sample < RAW_MIN) begin
			sat_code = CODE_NEG_FS;
		end else begin
			sat_code = raw_sample[WORD_W-1:0];
		end
	end

	sample_fifo #(
		.W(WORD_W),
		.D(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.clk_en(clk_en),
		.in_data(sat_code),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	assign fifo_pop = (state_q == ST_IDLE) && en;

	// Chain bit captured on shift clock rise
	always_ff @(posedge clk) begin
		if (rst) begin
			tag_q <= 1'b0;
		end else if (clk_en && rise) begin
			tag_q <= syn2_q[SYN_CHAIN];
		end
	end

	// Internal shift clock divider
	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= '0;
		end else if (clk_en) begin
			if (state_q != ST_READ || tick) begin
				div_q <= '0;
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	// Read cycle sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			start_tag_q <= 1'b0;
			cnt_q <= '0;
		end else if (clk_en) begin
			unique case (state_q)
				ST_IDLE: begin
					if (en) begin
						state_q <= ST_READ;
						start_tag_q <= syn2_q[SYN_CHAIN];
						cnt_q <= '0;
					end
				end
				ST_READ: begin
					if (!en) begin
						state_q <= ST_IDLE;
					end else if (shift_ev && cnt_q != SLOT_BITS) begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
			endcase
		end
	end

	// Shift register and output
	always_ff @(posedge clk) begin
		if (rst) begin
			sreg_q <= '0;
			serial_result_out <= 1'b0;
		end else if (clk_en) begin
			if (state_q == ST_IDLE) begin
				if (en && fifo_valid) begin
					sreg_q <= fifo_data;
				end
			end else if (!en) begin
				serial_result_out <= start_tag_q;
			end else if (!ext && cnt_q == SLOT_BITS) begin
				serial_result_out <= syn2_q[SYN_CHAIN];
				if (shift_ev) begin
					sreg_q <= {sreg_q[WORD_W-2:0], in_bit};
				end
			end else if (shift_ev) begin
				serial_result_out <= sreg_q[WORD_W-1];
				sreg_q <= {sreg_q[WORD_W-2:0], in_bit};
			end
		end
	end

	chk_end_level: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state_q == ST_READ && !en) |=>
		(serial_result_out == $past(start_tag_q)))
		else $error("output not at start chain level");

	chk_msb_first: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state_q == ST_READ && en && ext && fall && cnt_q == 4'h0)
		|=> (serial_result_out == $past(sreg_q[WORD_W-1])))
		else $error("first bit is not the msb");

	chk_slot_bound: assert property (@(posedge clk) disable iff (rst)
		cnt_q <= SLOT_BITS)
		else $error("bit count beyond slot");

	chk_sat_high: assert property (@(posedge clk) disable iff (rst)
		(raw_sample > RAW_MAX) |-> (sat_code == CODE_POS_FS))
		else $error("high input wrapped");

	chk_sat_low: assert property (@(posedge clk) disable iff (rst)
		(raw_sample < RAW_MIN) |-> (sat_code == CODE_NEG_FS))
		else $error("low input wrapped");

	chk_idle_hold: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state_q == ST_IDLE) |=> $stable(serial_result_out))
		else $error("output moved while not selected");

	chk_int_follow: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state_q == ST_READ && en && !ext && cnt_q == SLOT_BITS)
		|=> (serial_result_out == $past(syn2_q[SYN_CHAIN])))
		else $error("output not following chain input");

	chk_tag_shift: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state_q == ST_READ && en && ext && fall) |=>
		(sreg_q[0] == $past(tag_q)))
		else $error("chain bit not shifted in");

	chk_start_load: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state_q == ST_IDLE && en && fifo_valid) |=>
		(state_q == ST_READ && cnt_q == 4'h0 && sreg_q == $past(fifo_data)))
		else $error("read cycle did not load word");

	chk_bit_hold: assert property (@(posedge clk) disable iff (rst)
		(clk_en && state_q == ST_READ && en && !shift_ev &&
		(ext || cnt_q != SLOT_BITS)) |=> $stable(serial_result_out))
		else $error("output moved between shifts");
endmodule : chain_readout
`default_nettype wire

// ### sim/serial_reader_model.sv
/*
 Reader and upstream chain model facing the serial result readout.
 Assumes the bench calls burst after reset; shift clock period 160 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_reader_model (
	input wire logic clk,
	input wire logic serial_result_out,
	output logic shift_clock,
	output logic chip_select_n,
	output logic read_convert,
	output logic chain_in,
	output logic bit_ok,
	output logic bit_val
);
	import chain_readout_pkg::*;
	initial begin
		shift_clock = 1'b0;
		chip_select_n = 1'b1;
		read_convert = 1'b0;
		chain_in = 1'b0;
		bit_ok = 1'b0;
		bit_val = 1'b0;
	end
	task automatic grab();
		bit_ok <= 1'b1;
		bit_val <= serial_result_out;
		@(posedge clk);
		bit_ok <= 1'b0;
	endtask : grab
	task automatic close_read(input logic lvl, input int hold);
		if (hold != 0) begin
			chain_in <= !lvl;
			repeat (hold) @(posedge clk);
			grab();
		end
		chip_select_n <= 1'b1;
		read_convert <= 1'b0;
		repeat (8) @(posedge clk);
		grab();
	endtask : close_read
	task automatic burst(input int n, input logic [31:0] pat,
		input logic lvl, input int hold);
		int i;
		chain_in <= lvl;
		repeat (4) @(posedge clk);
		chip_select_n <= 1'b0;
		read_convert <= 1'b1;
		repeat (8) @(posedge clk);
		for (i = 0; i < n; i++) begin
			shift_clock <= 1'b1;
			chain_in <= pat[i];
			repeat (2) @(posedge clk);
			if (i != 0) grab();
			else @(posedge clk);
			@(posedge clk);
			shift_clock <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (2) @(posedge clk);
		if (n != 0) grab();
		close_read(lvl, hold);
	endtask : burst
	task automatic int_burst(input int n, input logic lvl, input int hold);
		int i;
		chain_in <= lvl;
		repeat (4) @(posedge clk);
		chip_select_n <= 1'b0;
		read_convert <= 1'b1;
		repeat (INT_CLK_CYCLES + INT_CLK_CYCLES / 2 + 3) @(posedge clk);
		for (i = 0; i < n; i++) begin
			grab();
			repeat (INT_CLK_CYCLES - 1) @(posedge clk);
		end
		close_read(lvl, hold);
	endtask : int_burst
endmodule : serial_reader_model
`default_nettype wire

// ### sim/daisy_chain_serial_readout_test.sv
/*
 Self-checking bench for the chain readout and its result FIFO.
 Assumes serial_reader_model drives the pins of the read side.
*/
`timescale 1ns/1ps
`default_nettype none
module daisy_chain_serial_readout_test;
	import chain_readout_pkg::*;
	logic clk, rst, clk_en, sel, valid, ready, sout;
	logic sck, cs_n, rc, chain, ok, val;
	logic signed [RAW_W-1:0] raw;
	logic signed [RAW_W-1:0] tv[6] = '{14'sh1fff, 14'sh2000, 14'sh0800,
		14'sh37ff, 14'sh07ff, 14'sh3800};
	logic [31:0] seed;
	logic [WORD_W-1:0] wq[$];
	logic exp_q[$];
	int fail_count, compares, cyc, k;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	chain_readout u_chain_readout (.clk(clk), .rst(rst), .clk_en(clk_en),
		.shift_clock(sck), .chip_select_n(cs_n), .read_convert(rc),
		.chain_in(chain), .clock_source_select(sel), .raw_sample(raw),
		.sample_valid(valid), .sample_ready(ready),
		.serial_result_out(sout));
	serial_reader_model u_serial_reader_model (.clk(clk),
		.serial_result_out(sout), .shift_clock(sck), .chip_select_n(cs_n),
		.read_convert(rc), .chain_in(chain), .bit_ok(ok), .bit_val(val));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [WORD_W-1:0] sat(input logic signed [RAW_W-1:0] v);
		if (v > RAW_MAX) return CODE_POS_FS;
		if (v < RAW_MIN) return CODE_NEG_FS;
		return v[WORD_W-1:0];
	endfunction : sat
	task automatic cmp(input string what, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic push(input logic signed [RAW_W-1:0] v);
		@(posedge clk);
		raw <= v;
		valid <= 1'b1;
		@(posedge clk);
		valid <= 1'b0;
		@(posedge clk);
		#1;
	endtask : push
	task automatic read(input int n, input int hold);
		logic [WORD_W-1:0] w;
		logic [31:0] p;
		logic l;
		int j;
		seed = lfsr(seed);
		p = seed;
		l = seed[7];
		w = wq.pop_front();
		for (j = 0; j < n; j++)
			exp_q.push_back(j < 12 ? w[11-j] : p[j-12]);
		if (hold != 0) exp_q.push_back(!l);
		exp_q.push_back(l);
		if (sel === 1'b1) u_serial_reader_model.burst(n, p, l, hold);
		else u_serial_reader_model.int_burst(n, l, hold);
	endtask : read
	always @(posedge clk) begin
		if (ok === 1'b1) begin
			if (exp_q.size() == 0) cmp("spare bit", 16'h1, 16'h0);
			else cmp("serial bit", {15'h0, exp_q.pop_front()}, {15'h0, val});
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		rst = 1'b1;
		clk_en = 1'b1;
		sel = 1'b1;
		valid = 1'b0;
		raw = '0;
		seed = 32'h872b2f79;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		cmp("ready after reset", 16'h1, {15'h0, ready});
		foreach (tv[i]) begin
			push(tv[i]);
			wq.push_back(sat(tv[i]));
		end
		read(26, 0);
		repeat (5) read(13, 0);
		$display("test saturate and chain done");
		@(posedge clk);
		clk_en <= 1'b0;
		push(14'sh0456);
		@(posedge clk);
		clk_en <= 1'b1;
		k = 0;
		while (ready === 1'b1 && k < 20) begin
			seed = lfsr(seed);
			push(seed[RAW_W-1:0]);
			wq.push_back(sat(seed[RAW_W-1:0]));
			k++;
		end
		cmp("fill count", 16'(FIFO_DEPTH), 16'(k));
		push(14'sh0123);
		repeat (16) read(13, 0);
		cmp("ready after drain", 16'h1, {15'h0, ready});
		$display("test fifo fill and drain done");
		push(14'sh0555);
		wq.push_back(12'h555);
		@(posedge clk);
		sel <= 1'b0;
		@(posedge clk);
		read(12, 640);
		$display("test internal clock done");
		repeat (2) @(posedge clk);
		cmp("notes left", 16'h0, 16'(exp_q.size()));
		final_report();
	end
endmodule : daisy_chain_serial_readout_test
`default_nettype wire
